// >>> include/pwmg_defs.svh
// constants for the pwm generator mode control block
// assumes inclusion by bare name from the design files
`ifndef PWMG_DEFS_SVH
`define PWMG_DEFS_SVH

// register byte offsets
`define PWMG_OFF_CTRL   8'h00
`define PWMG_OFF_CFG    8'h04
`define PWMG_OFF_DUTY   8'h08
`define PWMG_OFF_MDUTY  8'h0c
`define PWMG_OFF_DT     8'h10
`define PWMG_OFF_ALTDT  8'h14
`define PWMG_OFF_PHASE  8'h18
`define PWMG_OFF_PERIOD 8'h1c
`define PWMG_OFF_STATUS 8'h20

// control register fields
`define PWMG_DTMODE_HI 7
`define PWMG_DTMODE_LO 6
`define PWMG_POL_BIT 5
`define PWMG_TBSEL_BIT 3
`define PWMG_CENTER_BIT 2
`define PWMG_EXTRST_BIT 1
`define PWMG_IMMED_BIT 0
`define PWMG_CTRL_MASK 16'h00ef

// configuration register fields
`define PWMG_EN_BIT    0
`define PWMG_INDEP_BIT 1
`define PWMG_LIMMODE_BIT 2
`define PWMG_COMPL_BIT 3
`define PWMG_MDS_BIT   4
`define PWMG_CFG_W     5

// reset values
`define PWMG_CTRL_RST   16'h0000
`define PWMG_CFG_RST    5'h00
`define PWMG_VAL_RST    16'h0000
`define PWMG_PERIOD_RST 16'hffff
`define PWMG_CNT_SAT    16'hffff
`define PWMG_ONE        16'h0001

// register select codes
`define PWMG_SEL_NONE 4'hf
`endif

// >>> include/pwmg_pkg.sv
// types shared by the pwm generator mode control files
// assumes nothing beyond a sv compiler
package pwmg_pkg;
  // dead-time modes in field order 00,01,10,11
  typedef enum logic [1:0] {PWMG_DT_POS, PWMG_DT_NEG, PWMG_DT_OFF, PWMG_DT_COMP} pwmg_dt_mode_e;
  // time base count direction
  typedef enum logic {PWMG_UP, PWMG_DOWN} pwmg_dir_e;
endpackage

// >>> src/pwmg_deadtime.sv
// dead-time insertion and compensation for one output pair
// assumes raw waveform and timing values are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "pwmg_defs.svh"
module pwmg_deadtime import pwmg_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // waveform and mode
  input wire logic raw,
  input wire logic en,
  input wire logic complementary,
  input wire pwmg_dt_mode_e mode,
  input wire logic polarity,
  input wire logic comp_in,
  input wire logic [15:0] dt,
  input wire logic [15:0] alt_dt,
  // output pair
  output logic out_h,
  output logic out_l
);
  logic raw_q; // previous raw level
  logic [15:0] cnt_q; // cycles since last raw edge
  logic edge_w; // raw changed this cycle
  logic [15:0] cnt_eff; // count seen by this cycle
  logic ok_dt, ok_alt; // dead-time windows elapsed
  logic short_l, short_h; // compensation steering
  logic lo_raw; // low side source
  logic h_d, l_d; // next outputs
  pwmg_dt_mode_e mode_eff; // mode after output-mode check

  assign edge_w = raw ^ raw_q;
  assign cnt_eff = edge_w ? `PWMG_VAL_RST : cnt_q;
  assign ok_dt = cnt_eff >= dt;
  assign ok_alt = cnt_eff >= alt_dt;
  assign lo_raw = complementary ? ~raw : raw;
  assign mode_eff = (mode == PWMG_DT_NEG && !complementary) ? PWMG_DT_OFF : mode;
  assign short_l = (mode == PWMG_DT_COMP) && (polarity ? ~comp_in : comp_in);
  assign short_h = (mode == PWMG_DT_COMP) && (polarity ? comp_in : ~comp_in);

  // edge tracking and saturating count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_q <= 1'b0;
      cnt_q <= `PWMG_CNT_SAT;
    end else begin
      raw_q <= raw;
      if (edge_w) begin
        cnt_q <= `PWMG_ONE;
      end else if (cnt_q != `PWMG_CNT_SAT) begin
        cnt_q <= cnt_q + `PWMG_ONE;
      end
    end
  end

  // output shaping per mode
  always_comb begin
    h_d = 1'b0;
    l_d = 1'b0;
    unique case (mode_eff)
      PWMG_DT_POS: begin
        h_d = raw & ok_dt;
        l_d = lo_raw & ok_alt;
      end
      // overlap extends each side
      PWMG_DT_NEG: begin
        h_d = raw | ~ok_alt;
        l_d = ~raw | ~ok_dt;
      end
      // pass through
      PWMG_DT_OFF: begin
        h_d = raw;
        l_d = lo_raw;
      end
      PWMG_DT_COMP: begin
        h_d = raw & (~short_h | ok_dt);
        l_d = lo_raw & (~short_l | ok_dt);
      end
    endcase
  end

  // registered outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_h <= 1'b0;
      out_l <= 1'b0;
    end else begin
      out_h <= en & h_d;
      out_l <= en & l_d;
    end
  end

  a_pos_no_overlap: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(mode) == PWMG_DT_POS && $past(complementary)) |-> !(out_h && out_l))
    else $error("outputs overlap under positive dead time");
  a_pos_gap_low: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == PWMG_DT_POS && complementary && $fell(raw) && alt_dt > `PWMG_ONE) |=> !out_l)
    else $error("low output rose without dead time");
  a_off_follows: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == PWMG_DT_OFF && en) |=> (out_h == $past(raw)))
    else $error("high output not following raw when dead time off");
  a_pol_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    (mode != PWMG_DT_COMP) |-> (!short_l && !short_h))
    else $error("polarity acted outside compensation mode");
endmodule
`default_nettype wire

// >>> src/pwmg_top.sv
// pwm generator mode control with apb register access
// assumes master time base ticks and syncs are synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
`include "pwmg_defs.svh"
module pwmg_top import pwmg_pkg::*; #(
  parameter bit SEC_TB_PRESENT = 1'b1
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // master time bases
  input wire logic pri_tb_tick,
  input wire logic pri_tb_sync,
  input wire logic sec_tb_tick,
  input wire logic sec_tb_sync,
  // compensation and current limit
  input wire logic comp_input,
  input wire logic current_limit_event,
  // output pair
  output logic out_high_side,
  output logic out_low_side
);
  logic [15:0] ctrl_q; // pwm_generator_control
  logic [`PWMG_CFG_W-1:0] cfg_q; // enables and modes
  logic [15:0] duty_q, mduty_q, dt_q, altdt_q, phase_q, period_q; // written copies
  logic [15:0] act_duty_q, act_mduty_q, act_dt_q, act_altdt_q, act_phase_q; // active copies
  logic [15:0] cnt_q; // generator time base
  pwmg_dir_e dir_q; // count direction
  logic [31:0] rdata_d; // read mux
  logic setup_w, wr_w; // bus phases
  logic [3:0] sel_w; // decoded register
  logic pwm_en, indep, lim_mode, center, tick, sync, ext_rst, period_edge, raw;
  logic [15:0] use_duty; // duty in use

  // register decode shared by read and write
  function automatic logic [3:0] reg_sel(input logic [7:0] a);
    unique case (a)
      `PWMG_OFF_CTRL: reg_sel = 4'h0;
      `PWMG_OFF_CFG: reg_sel = 4'h1;
      `PWMG_OFF_DUTY: reg_sel = 4'h2;
      `PWMG_OFF_MDUTY: reg_sel = 4'h3;
      `PWMG_OFF_DT: reg_sel = 4'h4;
      `PWMG_OFF_ALTDT: reg_sel = 4'h5;
      `PWMG_OFF_PHASE: reg_sel = 4'h6;
      `PWMG_OFF_PERIOD: reg_sel = 4'h7;
      `PWMG_OFF_STATUS: reg_sel = 4'h8;
      default: reg_sel = `PWMG_SEL_NONE;
    endcase
  endfunction

  // bus phases; zero wait states
  assign pready = 1'b1;
  assign setup_w = psel & ~penable;
  assign wr_w = psel & penable & pwrite & (sel_w != `PWMG_SEL_NONE);
  assign sel_w = reg_sel(paddr);

  // mode bits
  assign pwm_en = cfg_q[`PWMG_EN_BIT];
  assign indep = cfg_q[`PWMG_INDEP_BIT];
  assign lim_mode = cfg_q[`PWMG_LIMMODE_BIT];
  assign center = ctrl_q[`PWMG_CENTER_BIT] & indep;
  assign tick = (ctrl_q[`PWMG_TBSEL_BIT] && SEC_TB_PRESENT) ? sec_tb_tick : pri_tb_tick;
  assign sync = (ctrl_q[`PWMG_TBSEL_BIT] && SEC_TB_PRESENT) ? sec_tb_sync : pri_tb_sync;
  assign ext_rst = ctrl_q[`PWMG_EXTRST_BIT] & indep & ~lim_mode & current_limit_event;
  // period boundary pulse
  assign period_edge = indep ? (tick & (center ? (dir_q == PWMG_DOWN && cnt_q == `PWMG_VAL_RST)
                                             : (cnt_q >= period_q)))
                           : sync;
  assign use_duty = cfg_q[`PWMG_MDS_BIT] ? act_mduty_q : act_duty_q;
  assign raw = pwm_en & (cnt_q < use_duty);

  // register writes, taken at access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `PWMG_CTRL_RST;
      cfg_q <= `PWMG_CFG_RST;
      duty_q <= `PWMG_VAL_RST;
      mduty_q <= `PWMG_VAL_RST;
      dt_q <= `PWMG_VAL_RST;
      altdt_q <= `PWMG_VAL_RST;
      phase_q <= `PWMG_VAL_RST;
      period_q <= `PWMG_PERIOD_RST;
    end else if (wr_w) begin
      unique case (sel_w)
        4'h0: ctrl_q <= pwdata[15:0] & `PWMG_CTRL_MASK;
        4'h1: cfg_q <= pwdata[`PWMG_CFG_W-1:0];
        4'h2: duty_q <= pwdata[15:0];
        4'h3: mduty_q <= pwdata[15:0];
        4'h4: dt_q <= pwdata[15:0];
        4'h5: altdt_q <= pwdata[15:0];
        4'h6: phase_q <= pwdata[15:0];
        4'h7: period_q <= pwdata[15:0];
        default: ; // status is read only
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_duty_q <= `PWMG_VAL_RST;
      act_mduty_q <= `PWMG_VAL_RST;
      act_dt_q <= `PWMG_VAL_RST;
      act_altdt_q <= `PWMG_VAL_RST;
      act_phase_q <= `PWMG_VAL_RST;
    end else if (ctrl_q[`PWMG_IMMED_BIT] || period_edge) begin
      act_duty_q <= duty_q;
      act_mduty_q <= mduty_q;
      act_dt_q <= dt_q;
      act_altdt_q <= altdt_q;
      act_phase_q <= phase_q;
    end
  end

  // generator time base
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= `PWMG_VAL_RST;
      dir_q <= PWMG_UP;
    end else if (ext_rst) begin
      cnt_q <= act_phase_q;
      dir_q <= PWMG_UP;
    end else if (!pwm_en) begin
      cnt_q <= `PWMG_VAL_RST;
      dir_q <= PWMG_UP;
    end else if (!indep) begin
      // follows selected master base
      dir_q <= PWMG_UP;
      if (sync) begin
        cnt_q <= act_phase_q;
      end else if (tick) begin
        cnt_q <= cnt_q + `PWMG_ONE;
      end
    end else if (tick) begin
      if (!center) begin
        // edge aligned wrap
        cnt_q <= (cnt_q >= period_q) ? `PWMG_VAL_RST : cnt_q + `PWMG_ONE;
        dir_q <= PWMG_UP;
      end else if (dir_q == PWMG_UP) begin
        // center aligned turn at top
        if (cnt_q >= period_q) begin
          dir_q <= PWMG_DOWN;
          cnt_q <= cnt_q - `PWMG_ONE;
        end else begin
          cnt_q <= cnt_q + `PWMG_ONE;
        end
      end else begin
        // center aligned turn at zero
        if (cnt_q == `PWMG_VAL_RST) begin
          dir_q <= PWMG_UP;
          cnt_q <= `PWMG_ONE;
        end else begin
          cnt_q <= cnt_q - `PWMG_ONE;
        end
      end
    end
  end

  // read mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (sel_w)
      4'h0: rdata_d[15:0] = ctrl_q;
      4'h1: rdata_d[`PWMG_CFG_W-1:0] = cfg_q;
      4'h2: rdata_d[15:0] = duty_q;
      4'h3: rdata_d[15:0] = mduty_q;
      4'h4: rdata_d[15:0] = dt_q;
      4'h5: rdata_d[15:0] = altdt_q;
      4'h6: rdata_d[15:0] = phase_q;
      4'h7: rdata_d[15:0] = period_q;
      4'h8: rdata_d = {13'h0, out_low_side, out_high_side, dir_q == PWMG_DOWN, cnt_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // read data and error latched in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_w) begin
      prdata <= rdata_d;
      pslverr <= (sel_w == `PWMG_SEL_NONE);
    end
  end

  pwmg_deadtime u_dt (
    .clk(pclk),
    .rst_n(presetn),
    .raw(raw),
    .en(pwm_en),
    .complementary(cfg_q[`PWMG_COMPL_BIT]),
    .mode(pwmg_dt_mode_e'(ctrl_q[`PWMG_DTMODE_HI:`PWMG_DTMODE_LO])),
    .polarity(ctrl_q[`PWMG_POL_BIT]),
    .comp_in(comp_input),
    .dt(act_dt_q),
    .alt_dt(act_altdt_q),
    .out_h(out_high_side),
    .out_l(out_low_side)
  );

  a_edge_no_indep: assert property (@(posedge pclk) disable iff (!presetn)
    (!indep && !ext_rst) |=> (dir_q == PWMG_UP))
    else $error("time base counted down without independent base");
  a_center_turn: assert property (@(posedge pclk) disable iff (!presetn)
    (center && pwm_en && tick && !ext_rst && dir_q == PWMG_UP && cnt_q >= period_q)
    |=> (dir_q == PWMG_DOWN))
    else $error("center aligned base did not turn at period");
  a_ext_restart: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q[`PWMG_EXTRST_BIT] && indep && !lim_mode && current_limit_event)
    |=> (cnt_q == $past(act_phase_q) && dir_q == PWMG_UP))
    else $error("current limit did not reset time base");
  a_limit_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    (lim_mode && indep && pwm_en && current_limit_event && !tick)
    |=> (cnt_q == $past(cnt_q)))
    else $error("time base reset while limit mode set");
  a_sec_sync: assert property (@(posedge pclk) disable iff (!presetn)
    (!indep && pwm_en && !ext_rst && ctrl_q[`PWMG_TBSEL_BIT] && sec_tb_sync && SEC_TB_PRESENT)
    |=> (cnt_q == $past(act_phase_q)))
    else $error("secondary sync not followed");
  a_iue_direct: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q[`PWMG_IMMED_BIT] && wr_w && sel_w == 4'h2) ##1 ctrl_q[`PWMG_IMMED_BIT]
    |=> (act_duty_q == $past(pwdata[15:0], 2)))
    else $error("immediate duty update not applied");
  a_sync_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl_q[`PWMG_IMMED_BIT] && !period_edge) |=> $stable(act_dt_q))
    else $error("dead time changed away from period boundary");
endmodule
`default_nettype wire

// >>> testbench/pwmg_power_stage.sv
// behavioural power stage hanging on the high and low output pair
// assumes both gate inputs change only on the rising edge of pclk
`timescale 1ns/1ps
`default_nettype none
module pwmg_power_stage (
  // clock and measurement restart
  input wire logic pclk,
  input wire logic clear,
  // gate drive pair
  input wire logic out_high_side,
  input wire logic out_low_side,
  // measured gaps and shoot-through
  output logic [7:0] gap_h,
  output logic [7:0] gap_l,
  output logic overlap
);
  logic [7:0] off_cnt = 8'h00; // cycles with both switches open
  logic prev_h = 1'b0; // last high gate level
  logic prev_l = 1'b0; // last low gate level
  // track off time and record it at each turn-on
  always_ff @(posedge pclk) begin
    prev_h <= out_high_side;
    prev_l <= out_low_side;
    off_cnt <= (out_high_side | out_low_side) ? 8'h00 : off_cnt + 8'h01;
    if (clear) begin
      gap_h <= 8'hff;
      gap_l <= 8'hff;
      overlap <= 1'b0;
    end else begin
      // a real bridge would short here
      if (out_high_side & out_low_side) overlap <= 1'b1;
      if (out_high_side & !prev_h) gap_h <= off_cnt;
      if (out_low_side & !prev_l) gap_l <= off_cnt;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/pwm_generator_mode_control_test.sv
// self-checking bench for the pwm generator mode control block
// assumes pwmg_top with an apb slave and the power stage model beside it
`timescale 1ns/1ps
`default_nettype none
`include "pwmg_defs.svh"
module pwm_generator_mode_control_test import pwmg_pkg::*;;
  // design stimulus, all quiet at time zero
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pri_tb_tick = 1'b0, pri_tb_sync = 1'b0, sec_tb_tick = 1'b0, sec_tb_sync = 1'b0;
  logic comp_input = 1'b0, current_limit_event = 1'b0, clear = 1'b0;
  // design and stage outputs
  logic [31:0] prdata;
  logic pready, pslverr, out_high_side, out_low_side, overlap;
  logic [7:0] gap_h, gap_l;
  logic [31:0] rdata; // last read word
  logic rerr; // last error flag
  int n_mismatch = 0, comparisons = 0, cycles = 0;

  pwmg_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pri_tb_tick(pri_tb_tick), .pri_tb_sync(pri_tb_sync),
    .sec_tb_tick(sec_tb_tick), .sec_tb_sync(sec_tb_sync), .comp_input(comp_input),
    .current_limit_event(current_limit_event), .out_high_side(out_high_side),
    .out_low_side(out_low_side));
  pwmg_power_stage i_stage (.pclk(pclk), .clear(clear), .out_high_side(out_high_side),
    .out_low_side(out_low_side), .gap_h(gap_h), .gap_l(gap_l), .overlap(overlap));

  // 250 mhz clock
  always #2 pclk = ~pclk;
  // hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rdata, exp);
  endtask

  task automatic cnt_chk(input string what, input logic [15:0] exp);
    apb(1'b0, `PWMG_OFF_STATUS, 32'h0);
    check(what, {16'h0, rdata[15:0]}, {16'h0, exp});
  endtask

  task automatic cfg_set(input logic [31:0] ctrl, input logic [31:0] cfg);
    apb(1'b1, `PWMG_OFF_CFG, 32'h0);
    apb(1'b1, `PWMG_OFF_CTRL, ctrl);
    apb(1'b1, `PWMG_OFF_CFG, cfg);
  endtask

  task automatic ticks(input logic sec, input int n);
    if (sec) sec_tb_tick <= 1'b1;
    else pri_tb_tick <= 1'b1;
    repeat (n) @(posedge pclk);
    sec_tb_tick <= 1'b0;
    pri_tb_tick <= 1'b0;
  endtask

  // one-cycle sync pulse on the chosen master base
  task automatic pulse_sync(input logic sec);
    if (sec) sec_tb_sync <= 1'b1;
    else pri_tb_sync <= 1'b1;
    @(posedge pclk);
    sec_tb_sync <= 1'b0;
    pri_tb_sync <= 1'b0;
  endtask

  task automatic evt_chk(input string what, input logic [15:0] exp);
    current_limit_event <= 1'b1;
    repeat (2) @(posedge pclk);
    current_limit_event <= 1'b0;
    cnt_chk(what, exp);
  endtask

  task automatic t_regs();
    rd_chk("ctrl reset", `PWMG_OFF_CTRL, 32'h0); // reset value
    rd_chk("period reset", `PWMG_OFF_PERIOD, 32'hffff); // reset value
    apb(1'b1, `PWMG_OFF_CTRL, 32'hffff);
    rd_chk("ctrl fields", `PWMG_OFF_CTRL, 32'hef);
    apb(1'b1, 8'h3c, 32'haa);
    check("unmapped error", {31'h0, rerr}, 32'h1); // unmapped
    rd_chk("unmapped data", 8'h3c, 32'h0); // unmapped
    apb(1'b0, `PWMG_OFF_STATUS, 32'h0);
    check("no irq status", rdata & 32'hfff8_0000, 32'h0);
  endtask

  // mode, polarity, comp input, high gap, low gap, overlap
  task automatic t_deadtime();
    logic [12:0] rows [8];
    logic [12:0] r;
    rows = '{{2'h0, 2'h0, 4'h4, 4'h3, 1'h0}, {2'h0, 2'h3, 4'h4, 4'h3, 1'h0},
      {2'h2, 2'h2, 4'h0, 4'h0, 1'h0}, {2'h1, 2'h0, 4'h0, 4'h0, 1'h1},
      {2'h3, 2'h2, 4'h0, 4'h4, 1'h0}, {2'h3, 2'h3, 4'h4, 4'h0, 1'h0},
      {2'h3, 2'h0, 4'h4, 4'h0, 1'h0}, {2'h3, 2'h1, 4'h0, 4'h4, 1'h0}};
    apb(1'b1, `PWMG_OFF_PERIOD, 32'hf);
    apb(1'b1, `PWMG_OFF_DUTY, 32'h6);
    apb(1'b1, `PWMG_OFF_DT, 32'h4);
    apb(1'b1, `PWMG_OFF_ALTDT, 32'h3);
    for (int i = 0; i < 8; i++) begin
      r = rows[i];
      comp_input <= r[9];
      cfg_set({24'h0, r[12:10], 5'h01}, 32'hb);
      pri_tb_tick <= 1'b1;
      clear <= 1'b1;
      @(posedge pclk);
      clear <= 1'b0;
      repeat (50) @(posedge pclk);
      pri_tb_tick <= 1'b0;
      check("high gap", {24'h0, gap_h}, {28'h0, r[8:5]});
      check("low gap", {24'h0, gap_l}, {28'h0, r[4:1]});
      check("overlap", {31'h0, overlap}, {31'h0, r[0]});
    end
  endtask

  task automatic t_align();
    logic down;
    for (int b = 0; b < 2; b++) begin
      cfg_set(32'h5, b[0] ? 32'h3 : 32'h1);
      pri_tb_tick <= 1'b1;
      down = 1'b0;
      repeat (20) begin
        apb(1'b0, `PWMG_OFF_STATUS, 32'h0);
        down = down | rdata[16];
      end
      pri_tb_tick <= 1'b0;
      check("counts down", {31'h0, down}, {31'h0, b[0]});
    end
  endtask

  task automatic t_tbsel();
    logic [15:0] c0;
    apb(1'b1, `PWMG_OFF_PHASE, 32'h9);
    for (int s = 0; s < 2; s++) begin
      cfg_set(s[0] ? 32'h9 : 32'h1, 32'h1);
      apb(1'b0, `PWMG_OFF_STATUS, 32'h0);
      c0 = rdata[15:0];
      ticks(!s[0], 5);
      cnt_chk("other base idle", c0);
      ticks(s[0], 5);
      cnt_chk("chosen base", c0 + 16'h5);
      pulse_sync(!s[0]);
      cnt_chk("other sync idle", c0 + 16'h5);
      pulse_sync(s[0]);
      cnt_chk("chosen sync", 16'h9);
    end
  endtask

  task automatic t_ext();
    logic [7:0] blk [3];
    blk = '{8'h37, 8'h13, 8'h31};
    cfg_set(32'h3, 32'h3);
    apb(1'b1, `PWMG_OFF_PHASE, 32'h7);
    ticks(1'b0, 10);
    evt_chk("limit reset", 16'h7);
    for (int i = 0; i < 3; i++) begin
      cfg_set({28'h0, blk[i][7:4]}, {28'h0, blk[i][3:0]});
      ticks(1'b0, 5);
      apb(1'b0, `PWMG_OFF_STATUS, 32'h0);
      evt_chk("reset blocked", rdata[15:0]);
    end
    cfg_set(32'h2, 32'h3);
    apb(1'b1, `PWMG_OFF_PHASE, 32'h3);
    evt_chk("phase held", 16'h7);
    ticks(1'b0, 40);
    evt_chk("phase at boundary", 16'h3);
  endtask

  // master duty select, dead time off, complementary pair
  task automatic t_mduty();
    cfg_set(32'h81, 32'h1b);
    apb(1'b1, `PWMG_OFF_MDUTY, 32'h10);
    ticks(1'b0, 20);
    check("mduty full high", {31'h0, out_high_side}, 32'h1);
    check("mduty full low", {31'h0, out_low_side}, 32'h0);
    apb(1'b1, `PWMG_OFF_MDUTY, 32'h0);
    ticks(1'b0, 5);
    check("mduty zero high", {31'h0, out_high_side}, 32'h0);
    check("mduty zero low", {31'h0, out_low_side}, 32'h1);
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_deadtime();
    t_align();
    t_tbsel();
    t_ext();
    t_mduty();
    print_verdict();
  end
endmodule
`default_nettype wire
